// ### hw/period_timer_pkg.sv
// constants, register offsets, field positions and reset values of the period timer
// assumes a plain register port with 8-bit data and one 40 MHz core clock
package period_timer_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h1;
    localparam logic [3:0] ADDR_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_CONTROL_B = 4'h3;
    localparam logic [3:0] ADDR_IRQ_FLAG = 4'h4;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
    localparam logic [3:0] ADDR_DUTY_LO = 4'h6;
    localparam logic [3:0] ADDR_DUTY_HI = 4'h7;
    localparam logic [3:0] ADDR_CCP_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_PIN_DIR = 4'h9;
    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int CTL_RUN_BIT = 7;
    localparam int CTL_PSEL_LSB = 4;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTLB_PSTS_LSB = 0;
    localparam int CTLB_EXT_LSB = 5;
    localparam logic [1:0] MODE_FREE = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_MONO = 2'h2;
    localparam logic [2:0] EXT_NONE = 3'h0;
    localparam logic [2:0] EXT_GATE_HIGH = 3'h1;
    localparam logic [2:0] EXT_GATE_LOW = 3'h2;
    localparam logic [2:0] EXT_RST_LEVEL = 3'h3;
    localparam logic [2:0] EXT_RST_RISE = 3'h4;
    localparam logic [2:0] EXT_RST_FALL = 3'h5;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] PIN_DIR_RESET = 8'h01;
endpackage : period_timer_pkg

// ### hw/period_timer_with_pwm.sv
// 8-bit period timer with prescaler, postscaler, shadow period and standard PWM output
// assumes i_ext_signal is asynchronous; register port strobes are synchronous one-cycle pulses
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module period_timer_with_pwm (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ext_signal,
    output logic o_postscaled_pulse,
    output logic o_irq,
    output logic [7:0] o_count,
    output logic o_period_match,
    output logic o_pwm_out,
    output logic o_pwm_oe
);
    // ----------------------------------------------------------------
    // reset release and external input synchroniser
    // ----------------------------------------------------------------
    logic rst_meta_reg, rst_sync_reg;
    logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rstn = rst_sync_reg;
    always_ff @(posedge i_core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end
        else
        begin
            ext_meta_reg <= i_ext_signal;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] count_reg, period_reg, shadow_reg, control_reg, control_b_reg;
    logic [7:0] duty_hi_reg, duty_buf_hi_reg;
    logic [1:0] duty_lo_reg, duty_buf_lo_reg;
    logic [6:0] presc_reg;
    logic [4:0] post_reg;
    logic flag_reg, irq_en_reg, ccp_en_reg, dir_reg, stopped_reg, pulse_reg, pwm_reg;
    logic [7:0] rdata_reg;
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire wr_count = i_wr && (i_addr == period_timer_pkg::ADDR_COUNT);
    wire wr_period = i_wr && (i_addr == period_timer_pkg::ADDR_PERIOD);
    wire wr_ctl = i_wr && (i_addr == period_timer_pkg::ADDR_CONTROL);
    wire wr_ctlb = i_wr && (i_addr == period_timer_pkg::ADDR_CONTROL_B);
    wire wr_flag = i_wr && (i_addr == period_timer_pkg::ADDR_IRQ_FLAG);
    wire wr_ien = i_wr && (i_addr == period_timer_pkg::ADDR_IRQ_ENABLE);
    wire wr_dlo = i_wr && (i_addr == period_timer_pkg::ADDR_DUTY_LO);
    wire wr_dhi = i_wr && (i_addr == period_timer_pkg::ADDR_DUTY_HI);
    wire wr_ccp = i_wr && (i_addr == period_timer_pkg::ADDR_CCP_CONTROL);
    wire wr_dir = i_wr && (i_addr == period_timer_pkg::ADDR_PIN_DIR);
    wire run = control_reg[period_timer_pkg::CTL_RUN_BIT];
    wire [2:0] psel = control_reg[period_timer_pkg::CTL_PSEL_LSB +: 3];
    wire [1:0] mode = control_reg[period_timer_pkg::CTL_MODE_LSB +: 2];
    wire [4:0] psts = control_b_reg[period_timer_pkg::CTLB_PSTS_LSB +: 5];
    wire [2:0] ext_mode = control_b_reg[period_timer_pkg::CTLB_EXT_LSB +: 3];
    // ratio is 2**psel: tick when all low psel bits of the prescaler are set
    wire [6:0] presc_mask = 7'((8'h01 << psel) - 8'h01);
    wire tick = ((presc_reg & presc_mask) == presc_mask);
    wire gate_ok = (ext_mode == period_timer_pkg::EXT_GATE_HIGH) ? ext_sync_reg :
                   (ext_mode == period_timer_pkg::EXT_GATE_LOW) ? !ext_sync_reg : 1'b1;
    wire ext_rst = ((ext_mode == period_timer_pkg::EXT_RST_LEVEL) && ext_sync_reg) ||
                   ((ext_mode == period_timer_pkg::EXT_RST_RISE) && ext_sync_reg && !ext_prev_reg) ||
                   ((ext_mode == period_timer_pkg::EXT_RST_FALL) && !ext_sync_reg && ext_prev_reg);
    wire count_en = run && !stopped_reg && gate_ok;
    wire sw_clr = wr_count || wr_ctl;
    wire match = (count_reg == shadow_reg);
    wire step = count_en && tick && !sw_clr && !ext_rst;
    wire match_evt = step && match;
    wire post_hit = (post_reg == psts);
    // ----------------------------------------------------------------
    // timer core
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_reg <= period_timer_pkg::COUNT_RESET;
            period_reg <= period_timer_pkg::PERIOD_RESET;
            shadow_reg <= period_timer_pkg::PERIOD_RESET;
            control_reg <= 8'h00;
            control_b_reg <= 8'h00;
            presc_reg <= 7'h00;
            post_reg <= 5'h00;
            stopped_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            if (wr_period)
                period_reg <= i_wdata;
            if (wr_ctlb)
                control_b_reg <= i_wdata;
            // software write wins over the one-shot clear of run enable
            if (wr_ctl)
                control_reg <= i_wdata;
            else if (match_evt && (mode == period_timer_pkg::MODE_ONESHOT))
                control_reg[period_timer_pkg::CTL_RUN_BIT] <= 1'b0;
            if (sw_clr || ext_rst)
            begin
                shadow_reg <= period_reg;
                presc_reg <= 7'h00;
                post_reg <= 5'h00;
                pulse_reg <= 1'b0;
                stopped_reg <= 1'b0;
                if (wr_count)
                    count_reg <= i_wdata;
                else if (ext_rst)
                    count_reg <= 8'h00;
            end
            else if (count_en)
            begin
                presc_reg <= 7'(presc_reg + 7'h01);
                if (tick)
                begin
                    pulse_reg <= match && post_hit;
                    if (match)
                    begin
                        count_reg <= 8'h00;
                        shadow_reg <= period_reg;
                        post_reg <= post_hit ? 5'h00 : 5'(post_reg + 5'h01);
                        if (mode != period_timer_pkg::MODE_FREE)
                            stopped_reg <= 1'b1;
                    end
                    else
                        count_reg <= 8'(count_reg + 8'h01);
                end
            end
            else if (tick)
                pulse_reg <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // interrupt flag, pwm unit and pin control
    // ----------------------------------------------------------------
    // duty latched at period end so a changing duty never gives a runt pulse
    wire [9:0] pwm_base = {count_reg, presc_reg[1:0]};
    wire [9:0] duty = {duty_buf_hi_reg, duty_buf_lo_reg};
    always_ff @(posedge i_core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            duty_hi_reg <= 8'h00;
            duty_lo_reg <= 2'h0;
            duty_buf_hi_reg <= 8'h00;
            duty_buf_lo_reg <= 2'h0;
            ccp_en_reg <= 1'b0;
            dir_reg <= period_timer_pkg::PIN_DIR_RESET[0];
            pwm_reg <= 1'b0;
        end
        else
        begin
            // hardware set wins over a clear in the same cycle
            if (match_evt)
                flag_reg <= 1'b1;
            else if (wr_flag)
                flag_reg <= i_wdata[0];
            if (wr_ien)
                irq_en_reg <= i_wdata[0];
            if (wr_dlo)
                duty_lo_reg <= i_wdata[1:0];
            if (wr_dhi)
                duty_hi_reg <= i_wdata;
            if (wr_ccp)
                ccp_en_reg <= i_wdata[0];
            if (wr_dir)
                dir_reg <= i_wdata[0];
            if (match_evt)
            begin
                duty_buf_hi_reg <= duty_hi_reg;
                duty_buf_lo_reg <= duty_lo_reg;
            end
            // low two duty bits resolve only with prescale ratio of four or more
            pwm_reg <= ccp_en_reg && (pwm_base < duty);
        end
    end
    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (i_addr)
            period_timer_pkg::ADDR_COUNT: rd_mux = count_reg;
            period_timer_pkg::ADDR_PERIOD: rd_mux = period_reg;
            period_timer_pkg::ADDR_CONTROL: rd_mux = control_reg;
            period_timer_pkg::ADDR_CONTROL_B: rd_mux = control_b_reg;
            period_timer_pkg::ADDR_IRQ_FLAG: rd_mux = {7'h00, flag_reg};
            period_timer_pkg::ADDR_IRQ_ENABLE: rd_mux = {7'h00, irq_en_reg};
            period_timer_pkg::ADDR_DUTY_LO: rd_mux = {6'h00, duty_lo_reg};
            period_timer_pkg::ADDR_DUTY_HI: rd_mux = duty_hi_reg;
            period_timer_pkg::ADDR_CCP_CONTROL: rd_mux = {7'h00, ccp_en_reg};
            period_timer_pkg::ADDR_PIN_DIR: rd_mux = {7'h00, dir_reg};
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge i_core_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= i_rd ? rd_mux : 8'h00;
    end
    assign o_rdata = rdata_reg;
    assign o_postscaled_pulse = pulse_reg;
    assign o_irq = flag_reg && irq_en_reg;
    assign o_count = count_reg;
    assign o_period_match = match && count_en && tick;
    // pwm_reg lags the enable by a cycle, so gate the pin with the enable itself
    assign o_pwm_out = pwm_reg && ccp_en_reg && !dir_reg;
    assign o_pwm_oe = ccp_en_reg && !dir_reg;
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rstn);
    chk_count_increments: assert property (step && !match |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not advance on tick");
    chk_count_wraps: assert property (match_evt |=> count_reg == 8'h00)
        else $error("count did not return to zero after match");
    chk_post_pulse: assert property (match_evt && post_hit |=> pulse_reg && post_reg == 5'h00)
        else $error("postscaled pulse missing");
    chk_gate_hold: assert property (!gate_ok && !sw_clr && !ext_rst |=> $stable(count_reg))
        else $error("count moved while gate inactive");
    chk_ext_reset: assert property (ext_rst && !wr_count |=> count_reg == 8'h00 && shadow_reg == $past(period_reg))
        else $error("external reset did not clear count");
    chk_shadow_load: assert property (sw_clr |=> shadow_reg == $past(period_reg) && presc_reg == 7'h00)
        else $error("shadow or prescaler not reloaded on write");
    chk_ctl_keeps_count: assert property (wr_ctl && !ext_rst |=> count_reg == $past(count_reg))
        else $error("control write changed count");
    chk_oneshot_stop: assert property (match_evt && mode == period_timer_pkg::MODE_ONESHOT && !wr_ctl |=> !run)
        else $error("one-shot did not clear run enable");
    chk_mono_hold: assert property (match_evt && mode == period_timer_pkg::MODE_MONO && !wr_ctl |=> run && stopped_reg)
        else $error("monostable did not stop with run kept");
    chk_irq_flag: assert property (match_evt |=> flag_reg ##0 (o_irq == irq_en_reg))
        else $error("match did not set interrupt flag");
    chk_pin_release: assert property (!ccp_en_reg || dir_reg |-> !o_pwm_oe && !o_pwm_out)
        else $error("pin driven while released");
endmodule : period_timer_with_pwm

// ### test/far_end_model.sv
// far-side model: external gate/reset source and a pulse consumer
// assumes the bench sets the wanted source level; one core clock
`timescale 1ns/100ps
module far_end_model (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_level,
    input wire logic i_pulse,
    output logic o_ext_signal,
    output logic [7:0] o_trigger_count
);
    // ----------------------------------------------------------------
    // source and consumer
    // ----------------------------------------------------------------
    logic pulse_reg;
    // source changes just after the edge, as a synchronous peripheral would
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_ext_signal <= 1'b0;
            pulse_reg <= 1'b0;
            o_trigger_count <= 8'h00;
        end
        else
        begin
            o_ext_signal <= i_level;
            pulse_reg <= i_pulse;
            // one trigger per pulse, however many ticks it lasts
            if (i_pulse && !pulse_reg)
                o_trigger_count <= o_trigger_count + 8'h01;
        end
    end
endmodule : far_end_model

// ### test/test_period_timer_with_pwm.sv
// self-checking bench of the period timer: register port, timer modes, pwm
// assumes 40 MHz core clock and the far-side model for the external source
`timescale 1ns/100ps
module test_period_timer_with_pwm;
    logic clk, rstn, wr, rd, level;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, cnt, trig, x, y;
    logic ext, pulse, irq, match, pwm, oe;
    int err_count, n_compared, m_cnt, p_cnt, w_cnt;
    period_timer_with_pwm DUT (.i_core_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_signal(ext), .o_postscaled_pulse(pulse),
        .o_irq(irq), .o_count(cnt), .o_period_match(match), .o_pwm_out(pwm), .o_pwm_oe(oe));
    far_end_model partner (.i_core_clk(clk), .i_resetn(rstn), .i_level(level), .i_pulse(pulse),
        .o_ext_signal(ext), .o_trigger_count(trig));
    // ----------------------------------------------------------------
    // bus, measurement and compare
    // ----------------------------------------------------------------
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // counts match cycles, pulse cycles and pwm-high cycles over n cycles
    task run(input int n);
        m_cnt = 0;
        p_cnt = 0;
        w_cnt = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            m_cnt += (match === 1'b1);
            p_cnt += (pulse === 1'b1);
            w_cnt += (pwm === 1'b1);
        end
    endtask : run
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task test_reset();
        rd_reg(period_timer_pkg::ADDR_PERIOD, x);
        chk("period", period_timer_pkg::PERIOD_RESET, x);
        rd_reg(period_timer_pkg::ADDR_COUNT, x);
        chk("count", period_timer_pkg::COUNT_RESET, x);
        rd_reg(period_timer_pkg::ADDR_PIN_DIR, x);
        chk("pin dir", period_timer_pkg::PIN_DIR_RESET, x);
        rd_reg(4'hf, x);
        chk("unmapped", 16'h0000, x);
    endtask : test_reset
    task test_free();
        wr_reg(period_timer_pkg::ADDR_PERIOD, 8'h03);
        wr_reg(period_timer_pkg::ADDR_CONTROL_B, 8'h01);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h80);
        x = trig;
        run(40);
        chk("matches", 16'd10, 16'(m_cnt));
        chk("pulses", 16'd5, 16'(p_cnt));
        // consumer counts a pulse one cycle after it rises
        @(posedge clk);
        #1;
        chk("triggers", 16'd5, {8'h00, trig - x});
        wr_reg(period_timer_pkg::ADDR_PERIOD, 8'h07);
        rd_reg(period_timer_pkg::ADDR_PERIOD, x);
        chk("period rd", 16'h0007, x);
        wr_reg(period_timer_pkg::ADDR_COUNT, 8'h00);
        run(64);
        chk("matches p7", 16'd8, 16'(m_cnt));
        // ratio 4 prescale, every match pulses
        wr_reg(period_timer_pkg::ADDR_CONTROL_B, 8'h00);
        wr_reg(period_timer_pkg::ADDR_PERIOD, 8'h03);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'ha0);
        // control write keeps the count, which may lie above the new period
        wr_reg(period_timer_pkg::ADDR_COUNT, 8'h00);
        run(67);
        chk("matches ps4", 16'd4, 16'(m_cnt));
        chk("pulse ticks", 16'd16, 16'(p_cnt));
    endtask : test_free
    task test_oneshot();
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h81);
        repeat (20) @(posedge clk);
        rd_reg(period_timer_pkg::ADDR_CONTROL, x);
        chk("run cleared", 16'h0001, x);
        run(20);
        chk("stopped", 16'd0, 16'(m_cnt));
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h01);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h81);
        run(12);
        chk("one match", 16'd1, 16'(m_cnt));
        chk("one pulse", 16'd1, 16'(p_cnt));
    endtask : test_oneshot
    task test_mono();
        wr_reg(period_timer_pkg::ADDR_CONTROL_B, 8'h80);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h82);
        repeat (20) @(posedge clk);
        rd_reg(period_timer_pkg::ADDR_CONTROL, x);
        chk("run kept", 16'h0082, x);
        run(20);
        chk("held", 16'd0, 16'(m_cnt));
        level <= 1'b1;
        run(20);
        chk("restart", 16'd1, 16'(m_cnt));
        level <= 1'b0;
    endtask : test_mono
    task test_gate();
        wr_reg(period_timer_pkg::ADDR_CONTROL_B, 8'h20);
        wr_reg(period_timer_pkg::ADDR_PERIOD, 8'hff);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h80);
        repeat (6) @(posedge clk);
        #1 x = cnt;
        repeat (10) @(posedge clk);
        #1 chk("gated", x, cnt);
        level <= 1'b1;
        repeat (6) @(posedge clk);
        #1 x = cnt;
        repeat (10) @(posedge clk);
        #1 chk("open", x + 8'd10, cnt);
        // level reset mode holds the count at zero
        wr_reg(period_timer_pkg::ADDR_CONTROL_B, 8'h60);
        repeat (10) @(posedge clk);
        chk("lvl reset", 16'h0000, cnt);
        level <= 1'b0;
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h80);
        repeat (9) @(posedge clk);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h00);
        rd_reg(period_timer_pkg::ADDR_COUNT, x);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h30);
        rd_reg(period_timer_pkg::ADDR_COUNT, y);
        chk("ctl keeps", x, y);
        wr_reg(period_timer_pkg::ADDR_COUNT, 8'h42);
        rd_reg(period_timer_pkg::ADDR_COUNT, x);
        chk("count rw", 16'h0042, x);
    endtask : test_gate
    task test_pwm();
        int i;
        wr_reg(period_timer_pkg::ADDR_CONTROL_B, 8'h00);
        wr_reg(period_timer_pkg::ADDR_PERIOD, 8'h03);
        wr_reg(period_timer_pkg::ADDR_DUTY_HI, 8'h02);
        wr_reg(period_timer_pkg::ADDR_DUTY_LO, 8'h00);
        wr_reg(period_timer_pkg::ADDR_CCP_CONTROL, 8'h01);
        wr_reg(period_timer_pkg::ADDR_IRQ_FLAG, 8'h00);
        wr_reg(period_timer_pkg::ADDR_IRQ_ENABLE, 8'h01);
        chk("oe tristate", 16'h0000, oe);
        // count left high by the previous scenario would delay the first match
        wr_reg(period_timer_pkg::ADDR_COUNT, 8'h00);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h80);
        for (i = 0; i < 100 && irq !== 1'b1; i++)
            @(posedge clk);
        chk("irq", 16'h0001, irq);
        // pin enabled only after the first match flag
        wr_reg(period_timer_pkg::ADDR_PIN_DIR, 8'h00);
        run(40);
        chk("duty", 16'd20, 16'(w_cnt));
        chk("oe on", 16'h0001, oe);
        wr_reg(period_timer_pkg::ADDR_CCP_CONTROL, 8'h00);
        run(8);
        chk("pwm off", 16'd0, 16'(w_cnt));
        chk("oe off", 16'h0000, oe);
        wr_reg(period_timer_pkg::ADDR_CONTROL, 8'h00);
        wr_reg(period_timer_pkg::ADDR_IRQ_FLAG, 8'h00);
        #1 chk("irq clr", 16'h0000, irq);
    endtask : test_pwm
    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #500000;
        err_count++;
        final_report();
    end
    initial
    begin
        {rstn, wr, rd, level, addr, wdata} = '0;
        err_count = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset();
        test_free();
        test_oneshot();
        test_mono();
        test_gate();
        test_pwm();
        final_report();
    end
endmodule : test_period_timer_with_pwm
